// [rtl/btrm_defs.svh]
`ifndef BTRM_DEFS_SVH
`define BTRM_DEFS_SVH
// Request kinds
`define BTRM_K_DW        2'h0
`define BTRM_K_DR        2'h1
`define BTRM_K_PW        2'h2
// Termination seen on the target bus
`define BTRM_T_NORMAL    3'h0
`define BTRM_T_RETRY     3'h1
`define BTRM_T_DISC      3'h2
`define BTRM_T_TABORT    3'h3
`define BTRM_T_MABORT    3'h4
// Answer given to the initiator
`define BTRM_A_NONE      3'h0
`define BTRM_A_ACCEPT    3'h1
`define BTRM_A_RETRY     3'h2
`define BTRM_A_DISC      3'h3
`define BTRM_A_TABORT    3'h4
// Bus commands touched by the write engine
`define BTRM_CMD_MW      4'h7
`define BTRM_CMD_MWI     4'hf
// Attempt limit, 2^24
`define BTRM_ATTEMPT_LIMIT 25'h1000000
// Least free room for a posted write, in Dwords
`define BTRM_PW_MIN_DW   8'h08
// Byte shift of one Dword
`define BTRM_DW_SHIFT    2
`define BTRM_FIFO_W      32
`define BTRM_FIFO_D      4
`endif

// [rtl/btrm_pkg.sv]
`include "btrm_defs.svh"
package btrm_pkg;
  // Delayed transaction slot
  typedef enum logic [4:0] {
    DT_IDLE  = 5'b00001,
    DT_ISSUE = 5'b00010,
    DT_WAIT  = 5'b00100,
    DT_DONE  = 5'b01000,
    DT_ABORT = 5'b10000
  } btrm_dt_e;
  // Posted write engine
  typedef enum logic [3:0] {
    PW_IDLE  = 4'b0001,
    PW_ISSUE = 4'b0010,
    PW_WAIT  = 4'b0100,
    PW_FLUSH = 4'b1000
  } btrm_pw_e;
  typedef struct packed {
    btrm_dt_e    dt_st;
    logic [1:0]  dt_kind;
    logic [31:0] dt_addr;
    logic [3:0]  dt_cmd;
    logic [2:0]  dt_res;
    logic [24:0] dt_cnt;
    btrm_pw_e    pw_st;
    logic [31:0] pw_addr;
    logic [3:0]  pw_cmd;
    logic [15:0] pw_rem;
    logic [15:0] pw_pend;
    logic [24:0] pw_cnt;
    logic [15:0] att_dw;
    logic        busy;
    logic        own_pw;
    logic        tgt_start;
    logic [31:0] tgt_addr;
    logic [3:0]  tgt_cmd;
    logic        ans_valid;
    logic [2:0]  ans_code;
    logic        wvalid;
    logic [31:0] wdata;
    logic        rx_tabort;
    logic        sig_tabort;
    logic        sig_serr;
    logic        serr_n;
  } btrm_state_s;
endpackage

// [rtl/btrm_handler.sv]
`timescale 1ns/1ps
`include "btrm_defs.svh"

// Small FIFO on the posted write data path
module btrm_fifo #(
  parameter int W = `BTRM_FIFO_W,
  parameter int D = `BTRM_FIFO_D
) (
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } btrm_fifo_s;
  btrm_fifo_s q, d;
  logic       push;
  logic       pop;

  // Ready and valid come from the stored count
  assign o_in_ready  = (q.cnt != (AW+1)'(D));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = q.mem[q.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  // Pointers wrap because the depth is a power of two
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = i_in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (pop)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      q <= '0;
    else
      q <= d;
  end
endmodule

// Behaviour
// - Delayed write done normally or disconnected: disconnect with first data if multi-phase.
// - Delayed write retried by target: retry initiator, keep reattempting.
// - Target abort on delayed transfer: target abort back, set both abort flags.
// - Delayed write repeats until data moves, any abort, or 2^24 retries.
// - Delayed write hits 2^24: discard, system error if enabled, abort next attempt.
// - Posted write retried: repeat with identical start address.
// - Posted write disconnected with data left: restart at current Dword address.
// - Memory write and invalidate disconnected after some data continues as plain memory write.
// - Posted write target abort: received flag, system error and its flag if enabled.
// - Posted write fails 2^24 attempts: discard data, system error if enabled.
// - Delayed read normal: prefetchable disconnects if more wanted, else first phase.
// - Delayed read retried by target: reinitiate the read.
// - Delayed read disconnected: disconnect initiator if it wants more than read.
// - Delayed read repeats until done; 2^24 retries discard, error, abort next.
// - Delayed write retried while queuing, full, duplicate, pending or not at head.
// - Delayed read retried while queuing, full, duplicate, data unready, or discarding.
// - Posted write retried without room for address plus 8 Dwords.
// - Locked sequence in flight: retry every non-locked transfer.
// - Retried initiator must repeat in time, else transaction is dropped.
// - Disconnect at address boundary, no write room, or no read data left.
// - Every target abort returned sets the signaled target abort flag.
module btrm_handler
  import btrm_pkg::*;
#(
  parameter logic [24:0] P_ATTEMPT_LIMIT = `BTRM_ATTEMPT_LIMIT
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_req_valid,
  input  wire logic [1:0]  i_req_kind,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [3:0]  i_req_cmd,
  input  wire logic        i_req_locked,
  input  wire logic        i_req_multi,
  input  wire logic        i_req_prefetch,
  input  wire logic        i_req_more,
  input  wire logic [15:0] i_req_dwords,
  input  wire logic        i_dq_full,
  input  wire logic        i_dq_dup,
  input  wire logic        i_resp_not_head,
  input  wire logic        i_rd_behind_pw,
  input  wire logic        i_rd_discarding,
  input  wire logic [7:0]  i_pw_space_dw,
  input  wire logic        i_lock_active,
  input  wire logic        i_boundary,
  input  wire logic        i_no_wr_room,
  input  wire logic        i_no_rd_data,
  input  wire logic        i_mto_expire,
  input  wire logic        i_serr_en,
  input  wire logic        i_dis_dw_lim,
  input  wire logic        i_dis_dr_lim,
  input  wire logic        i_dis_pw_lim,
  input  wire logic        i_dis_pw_tabort,
  input  wire logic        i_clr_rx_tabort,
  input  wire logic        i_clr_sig_tabort,
  input  wire logic        i_clr_sig_serr,
  input  wire logic        i_pw_valid,
  input  wire logic [31:0] i_pw_data,
  output logic             o_pw_ready,
  output logic             o_ans_valid,
  output logic [2:0]       o_ans_code,
  output logic             o_tgt_start,
  output logic [31:0]      o_tgt_addr,
  output logic [3:0]       o_tgt_cmd,
  output logic             o_tgt_posted,
  input  wire logic        i_tgt_done,
  input  wire logic [2:0]  i_tgt_term,
  output logic             o_tgt_wvalid,
  output logic [31:0]      o_tgt_wdata,
  input  wire logic        i_tgt_wready,
  output logic             o_rx_tabort,
  output logic             o_sig_tabort,
  output logic             o_sig_serr,
  output logic             o_serr_n
);
  btrm_state_s q, d;
  logic        f_valid;
  logic [31:0] f_data;
  logic        f_pop;
  logic        f_ready;
  logic        match;
  logic        set_rx;
  logic        set_sta;
  logic        set_serr;
  logic        dt_done;
  logic        pw_done;
  logic [24:0] dt_cnt_n;
  logic [24:0] pw_cnt_n;
  logic [15:0] rem_n;

  btrm_fifo #(
    .W (`BTRM_FIFO_W),
    .D (`BTRM_FIFO_D)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_resetn    (i_resetn),
    .i_in_valid  (i_pw_valid),
    .i_in_data   (i_pw_data),
    .o_in_ready  (f_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_pop)
  );

  // Ready to the source stalls when the FIFO fills
  assign o_pw_ready = f_ready;

  // Same request again: address, command and kind all agree
  assign match    = (i_req_addr == q.dt_addr) && (i_req_cmd == q.dt_cmd) && (i_req_kind == q.dt_kind);
  assign dt_done  = q.busy && !q.own_pw && i_tgt_done;
  assign pw_done  = q.busy && q.own_pw && i_tgt_done;
  assign dt_cnt_n = q.dt_cnt + 25'h1;
  assign pw_cnt_n = q.pw_cnt + 25'h1;
  assign rem_n    = q.pw_rem - q.att_dw;

  // Data word stage toward the target; a flush drops words instead of sending them
  always_comb
  begin
    f_pop = 1'b0;
    if (q.pw_st == PW_FLUSH)
      f_pop = f_valid && (q.pw_pend != 16'h0);
    else if ((q.pw_st != PW_IDLE) && (!q.wvalid || i_tgt_wready))
      f_pop = f_valid && (q.pw_pend != 16'h0);
  end

  always_comb
  begin
    d           = q;
    d.tgt_start = 1'b0;
    d.ans_valid = 1'b0;
    d.ans_code  = `BTRM_A_NONE;
    d.serr_n    = 1'b1;
    set_rx      = 1'b0;
    set_sta     = 1'b0;
    set_serr    = 1'b0;

    // Output word register and per-attempt Dword count
    if (q.wvalid && i_tgt_wready)
    begin
      d.wvalid = 1'b0;
      if (q.busy && q.own_pw)
        d.att_dw = q.att_dw + 16'h1;
    end
    if (f_pop)
      d.pw_pend = q.pw_pend - 16'h1;
    if (f_pop && (q.pw_st != PW_FLUSH))
    begin
      d.wvalid = 1'b1;
      d.wdata  = f_data;
    end
    if (q.pw_st == PW_FLUSH)
      d.wvalid = 1'b0;

    // Initiator side: one answer per request, lock checked first
    if (i_req_valid)
    begin
      d.ans_valid = 1'b1;
      if (i_lock_active && !i_req_locked)
        d.ans_code = `BTRM_A_RETRY;
      else if (i_req_kind == `BTRM_K_PW)
      begin
        if ((i_pw_space_dw < `BTRM_PW_MIN_DW) || (q.pw_st != PW_IDLE))
          d.ans_code = `BTRM_A_RETRY;
        else
        begin
          d.ans_code = (i_boundary || i_no_wr_room) ? `BTRM_A_DISC : `BTRM_A_ACCEPT;
          d.pw_st    = PW_ISSUE;
          d.pw_addr  = i_req_addr;
          d.pw_cmd   = i_req_cmd;
          d.pw_rem   = i_req_dwords;
          d.pw_pend  = i_req_dwords;
          d.pw_cnt   = 25'h0;
        end
      end
      else if ((q.dt_st == DT_ABORT) && match)
      begin
        // Limit reached earlier: this repeat gets the abort
        d.ans_code = `BTRM_A_TABORT;
        set_sta    = 1'b1;
        d.dt_st    = DT_IDLE;
      end
      else if ((q.dt_st == DT_DONE) && match)
      begin
        if (i_resp_not_head || ((i_req_kind == `BTRM_K_DR) && (i_rd_behind_pw || i_rd_discarding)))
          d.ans_code = `BTRM_A_RETRY;
        else
        begin
          d.dt_st  = DT_IDLE;
          d.dt_cnt = 25'h0;
          if (q.dt_res == `BTRM_T_TABORT)
          begin
            d.ans_code = `BTRM_A_TABORT;
            set_sta    = 1'b1;
          end
          else if (q.dt_kind == `BTRM_K_DW)
            d.ans_code = i_req_multi ? `BTRM_A_DISC : `BTRM_A_ACCEPT;
          else if ((q.dt_res == `BTRM_T_NORMAL) && !i_req_prefetch)
            d.ans_code = `BTRM_A_DISC;
          else if (i_req_more || i_boundary || i_no_rd_data)
            d.ans_code = `BTRM_A_DISC;
          else
            d.ans_code = `BTRM_A_ACCEPT;
        end
      end
      else if ((q.dt_st != DT_IDLE) || i_dq_full || i_dq_dup)
        d.ans_code = `BTRM_A_RETRY;
      else
      begin
        // Enter the slot; the initiator is retried meanwhile
        d.ans_code = `BTRM_A_RETRY;
        d.dt_st    = DT_ISSUE;
        d.dt_kind  = i_req_kind;
        d.dt_addr  = i_req_addr;
        d.dt_cmd   = i_req_cmd;
        d.dt_cnt   = 25'h0;
      end
    end

    // Initiator gave up repeating in time: drop the slot unless an attempt is out
    if (i_mto_expire && (q.dt_st != DT_WAIT) && (q.dt_st != DT_IDLE))
      d.dt_st = DT_IDLE;

    // Target side: posted writes go first to keep write ordering
    if (!q.busy)
    begin
      if (q.pw_st == PW_ISSUE)
      begin
        d.tgt_start = 1'b1;
        d.tgt_addr  = q.pw_addr;
        d.tgt_cmd   = q.pw_cmd;
        d.busy      = 1'b1;
        d.own_pw    = 1'b1;
        d.att_dw    = 16'h0;
        d.pw_st     = PW_WAIT;
      end
      else if (q.dt_st == DT_ISSUE)
      begin
        d.tgt_start = 1'b1;
        d.tgt_addr  = q.dt_addr;
        d.tgt_cmd   = q.dt_cmd;
        d.busy      = 1'b1;
        d.own_pw    = 1'b0;
        d.dt_st     = DT_WAIT;
      end
    end

    // Delayed attempt finished
    if (dt_done)
    begin
      d.busy = 1'b0;
      case (i_tgt_term)
        `BTRM_T_RETRY:
        begin
          d.dt_cnt = dt_cnt_n;
          if (dt_cnt_n == P_ATTEMPT_LIMIT)
          begin
            d.dt_st = DT_ABORT;
            if (i_serr_en && !((q.dt_kind == `BTRM_K_DW) ? i_dis_dw_lim : i_dis_dr_lim))
            begin
              d.serr_n = 1'b0;
              set_serr = 1'b1;
            end
          end
          else
            d.dt_st = DT_ISSUE;
        end
        `BTRM_T_TABORT:
        begin
          set_rx   = 1'b1;
          d.dt_res = i_tgt_term;
          d.dt_st  = DT_DONE;
        end
        default:
        begin
          d.dt_res = i_tgt_term;
          d.dt_st  = DT_DONE;
        end
      endcase
      // A drop requested in the same cycle the attempt ends lands here
      if (i_mto_expire)
        d.dt_st = DT_IDLE;
    end

    // Posted attempt finished
    if (pw_done)
    begin
      d.busy = 1'b0;
      d.pw_cnt = pw_cnt_n;
      case (i_tgt_term)
        `BTRM_T_NORMAL:
        begin
          d.pw_rem = rem_n;
          d.pw_st  = (rem_n == 16'h0) ? PW_IDLE : PW_ISSUE;
        end
        `BTRM_T_RETRY:
          d.pw_st = PW_ISSUE;
        `BTRM_T_DISC:
        begin
          d.pw_rem  = rem_n;
          d.pw_addr = q.pw_addr + {q.att_dw[13:0], 2'b00};
          if ((q.att_dw != 16'h0) && (q.pw_cmd == `BTRM_CMD_MWI))
            d.pw_cmd = `BTRM_CMD_MW;
          d.pw_st = (rem_n == 16'h0) ? PW_IDLE : PW_ISSUE;
        end
        `BTRM_T_TABORT:
        begin
          set_rx  = 1'b1;
          d.pw_st = PW_FLUSH;
          if (i_serr_en && !i_dis_pw_tabort)
          begin
            d.serr_n = 1'b0;
            set_serr = 1'b1;
          end
        end
        default:
          d.pw_st = PW_FLUSH;
      endcase
      // Limit only counts while data is still undelivered
      if ((pw_cnt_n == P_ATTEMPT_LIMIT) && (d.pw_st == PW_ISSUE))
      begin
        d.pw_st = PW_FLUSH;
        if (i_serr_en && !i_dis_pw_lim)
        begin
          d.serr_n = 1'b0;
          set_serr = 1'b1;
        end
      end
    end

    // Flush ends once every word of the dropped write has left the FIFO
    if ((q.pw_st == PW_FLUSH) && (d.pw_pend == 16'h0))
      d.pw_st = PW_IDLE;

    // Sticky flags: a set in the clearing cycle wins
    d.rx_tabort  = (q.rx_tabort && !i_clr_rx_tabort) || set_rx;
    d.sig_tabort = (q.sig_tabort && !i_clr_sig_tabort) || set_sta;
    d.sig_serr   = (q.sig_serr && !i_clr_sig_serr) || set_serr;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      q        <= '0;
      q.dt_st  <= DT_IDLE;
      q.pw_st  <= PW_IDLE;
      q.serr_n <= 1'b1;
    end
    else
      q <= d;
  end

  // Every output except o_pw_ready straight from the state register
  assign o_ans_valid  = q.ans_valid;
  assign o_ans_code   = q.ans_code;
  assign o_tgt_start  = q.tgt_start;
  assign o_tgt_addr   = q.tgt_addr;
  assign o_tgt_cmd    = q.tgt_cmd;
  assign o_tgt_posted = q.own_pw;
  assign o_tgt_wvalid = q.wvalid;
  assign o_tgt_wdata  = q.wdata;
  assign o_rx_tabort  = q.rx_tabort;
  assign o_sig_tabort = q.sig_tabort;
  assign o_sig_serr   = q.sig_serr;
  assign o_serr_n     = q.serr_n;

  // Checks
  AST_LOCK_RETRY: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_req_valid && i_lock_active && !i_req_locked |=> o_ans_valid && (o_ans_code == `BTRM_A_RETRY))
    else $error("Non-locked request not retried during lock");
  AST_PW_ROOM: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_req_valid && !i_lock_active && (i_req_kind == `BTRM_K_PW) && (i_pw_space_dw < `BTRM_PW_MIN_DW)
    |=> o_ans_code == `BTRM_A_RETRY)
    else $error("Posted write accepted without room");
  AST_TA_FLAG: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_ans_valid && (o_ans_code == `BTRM_A_TABORT) |-> o_sig_tabort)
    else $error("Target abort returned without flag");
  AST_RX_TA: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    q.busy && i_tgt_done && (i_tgt_term == `BTRM_T_TABORT) |=> o_rx_tabort)
    else $error("Received target abort flag not set");
  AST_DT_REISSUE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    dt_done && (i_tgt_term == `BTRM_T_RETRY) && (dt_cnt_n != P_ATTEMPT_LIMIT) && !i_mto_expire
    |=> ##[0:1] o_tgt_start || q.busy)
    else $error("Retried delayed transfer not reattempted");
  AST_PW_SAME_ADDR: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    pw_done && (i_tgt_term == `BTRM_T_RETRY) |=> q.pw_addr == $past(q.pw_addr))
    else $error("Retried posted write moved its address");
  AST_PW_DISC_ADDR: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    pw_done && (i_tgt_term == `BTRM_T_DISC)
    |=> q.pw_addr == $past(q.pw_addr) + {$past(q.att_dw[13:0]), 2'b00})
    else $error("Disconnected posted write address not advanced");
  AST_MWI_TO_MW: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    pw_done && (i_tgt_term == `BTRM_T_DISC) && (q.att_dw != 16'h0) |=> q.pw_cmd != `BTRM_CMD_MWI)
    else $error("Invalidate command kept after partial delivery");
  AST_SERR_CAUSE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $fell(o_serr_n) |-> $past(i_serr_en) && o_sig_serr)
    else $error("System error without enable");
  AST_START_PULSE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_tgt_start |=> !o_tgt_start)
    else $error("Attempt start longer than one cycle");
endmodule

// [tb/btrm_tgt_model.sv]
`timescale 1ns/1ps
// Far-bus target: waits, takes a set number of words, then ends with a set code
module btrm_tgt_model (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic       i_wvalid,
  input  wire logic [2:0] i_term,
  input  wire logic [3:0] i_words,
  input  wire logic [3:0] i_lat,
  output logic            o_done,
  output logic [2:0]      o_term,
  output logic            o_wready
);
  logic       busy_q;
  logic [3:0] lat_q;
  logic [3:0] cnt_q;
  logic [3:0] words_q;
  logic [2:0] term_q;
  // Code lines toggle outside a done pulse so a stale code never looks valid
  always_ff @(posedge i_mclk)
  begin
    o_done <= 1'b0;
    o_term <= ~o_term;
    if (!i_resetn)
    begin
      busy_q   <= 1'b0;
      o_wready <= 1'b0;
      o_term   <= 3'h0;
    end
    else if (i_start)
    begin
      busy_q  <= 1'b1;
      lat_q   <= i_lat;
      cnt_q   <= 4'h0;
      words_q <= i_words;
      term_q  <= i_term;
    end
    else if (busy_q && lat_q != 4'h0)
      lat_q <= lat_q - 4'h1;
    else if (busy_q && o_wready && i_wvalid)
    begin
      cnt_q    <= cnt_q + 4'h1;
      o_wready <= (cnt_q + 4'h1 != words_q);
    end
    else if (busy_q && cnt_q == words_q && !o_wready)
    begin
      o_done <= 1'b1;
      o_term <= term_q;
      busy_q <= 1'b0;
    end
    else if (busy_q)
      o_wready <= 1'b1;
  end
endmodule

// [tb/test_bridge_termination_handler.sv]
`timescale 1ns/1ps
`include "btrm_defs.svh"
module test_bridge_termination_handler;
  localparam int LIMN = 4;
  localparam logic [2:0] TC [4] = '{`BTRM_T_NORMAL, `BTRM_T_DISC, `BTRM_T_TABORT, `BTRM_T_MABORT};
  logic        i_mclk, i_resetn, i_req_valid, i_req_locked, i_req_multi, i_req_prefetch, i_req_more;
  logic        i_dq_full, i_dq_dup, i_resp_not_head, i_rd_behind_pw, i_rd_discarding, i_lock_active;
  logic        i_boundary, i_no_rd_data, i_serr_en, i_pw_valid, o_pw_ready, o_ans_valid, o_tgt_start;
  logic        o_tgt_posted, i_tgt_done, o_tgt_wvalid, i_tgt_wready, o_rx_tabort, o_sig_tabort;
  logic        o_sig_serr, o_serr_n, st_post, i_no_wr_room, i_mto_expire;
  logic [1:0]  i_req_kind, k;
  logic [31:0] i_req_addr, i_pw_data, o_tgt_addr, o_tgt_wdata, rnd, st_addr, base;
  logic [3:0]  i_req_cmd, o_tgt_cmd, st_cmd, m_lat, m_words, dis, c;
  logic [2:0]  clr, o_ans_code, i_tgt_term, m_term, t;
  logic [15:0] i_req_dwords;
  logic [7:0]  i_pw_space_dw;
  logic [4:0]  frc, f;
  int          err_count, total_checks, cyc, starts, dones, serrs, s0, v0;
  logic [31:0] exp_q[$];
  assign {i_dq_full, i_dq_dup, i_resp_not_head, i_rd_behind_pw, i_rd_discarding} = frc;

  btrm_handler #(.P_ATTEMPT_LIMIT(25'(LIMN))) btrm_handler_i (
    .i_mclk, .i_resetn, .i_req_valid, .i_req_kind, .i_req_addr, .i_req_cmd, .i_req_locked,
    .i_req_multi, .i_req_prefetch, .i_req_more, .i_req_dwords, .i_dq_full, .i_dq_dup,
    .i_resp_not_head, .i_rd_behind_pw, .i_rd_discarding, .i_pw_space_dw, .i_lock_active,
    .i_boundary, .i_no_wr_room, .i_no_rd_data, .i_mto_expire, .i_serr_en,
    .i_dis_dw_lim(dis[3]), .i_dis_dr_lim(dis[2]), .i_dis_pw_lim(dis[1]), .i_dis_pw_tabort(dis[0]),
    .i_clr_rx_tabort(clr[2]), .i_clr_sig_tabort(clr[1]), .i_clr_sig_serr(clr[0]), .i_pw_valid,
    .i_pw_data, .o_pw_ready, .o_ans_valid, .o_ans_code, .o_tgt_start, .o_tgt_addr, .o_tgt_cmd,
    .o_tgt_posted, .i_tgt_done, .i_tgt_term, .o_tgt_wvalid, .o_tgt_wdata, .i_tgt_wready,
    .o_rx_tabort, .o_sig_tabort, .o_sig_serr, .o_serr_n);
  btrm_tgt_model btrm_tgt_model_i (
    .i_mclk, .i_resetn, .i_start(o_tgt_start), .i_wvalid(o_tgt_wvalid), .i_term(m_term),
    .i_words(m_words), .i_lat(m_lat), .o_done(i_tgt_done), .o_term(i_tgt_term), .o_wready(i_tgt_wready));

  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Answer owed to a repeat of a finished delayed transfer; f is multi, prefetch, more, boundary, empty
  function automatic logic [2:0] exp_ans(input logic [1:0] kk, input logic [2:0] tt, input logic [4:0] ff);
    if (tt == `BTRM_T_TABORT) return `BTRM_A_TABORT;
    if (kk == `BTRM_K_DW) return ff[4] ? `BTRM_A_DISC : `BTRM_A_ACCEPT;
    if (tt == `BTRM_T_NORMAL && !ff[3]) return `BTRM_A_DISC;
    return (ff[2] | ff[1] | ff[0]) ? `BTRM_A_DISC : `BTRM_A_ACCEPT;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded wait; a count that never arrives shows up in the next comparison
  task automatic wait_for(ref int cnt, input int v);
    int n;
    n = 0;
    while (cnt < v && n < 300)
    begin
      @(negedge i_mclk);
      n++;
    end
  endtask
  // One initiator request, answer checked one to four cycles on
  task automatic req(input logic [1:0] kk, input logic [31:0] a, input logic [3:0] cc, input logic [2:0] e);
    int n;
    @(negedge i_mclk);
    i_req_valid = 1'b1;
    i_req_kind = kk;
    i_req_addr = a;
    i_req_cmd = cc;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    n = 0;
    while (o_ans_valid !== 1'b1 && n < 3)
    begin
      @(negedge i_mclk);
      n++;
    end
    check(o_ans_code, e);
  endtask
  // Follow one posted attempt, then set up the far side for the next
  task automatic attempt(input logic [31:0] a, input logic [3:0] cc, input logic [2:0] tt, input logic [3:0] w);
    wait_for(starts, s0 + 1);
    check({st_post, st_cmd, st_addr}, {1'b1, cc, a});
    wait_for(dones, v0 + 1);
    m_term = tt;
    m_words = w;
    s0 = starts;
    v0 = dones;
  endtask

  // Count far-side events and check each delivered word in order
  always @(negedge i_mclk)
  begin
    if (o_tgt_start === 1'b1)
    begin
      starts++;
      st_addr = o_tgt_addr;
      st_cmd = o_tgt_cmd;
      st_post = o_tgt_posted;
    end
    dones += int'(i_tgt_done === 1'b1);
    serrs += int'(o_serr_n === 1'b0);
    if (o_tgt_wvalid === 1'b1 && i_tgt_wready === 1'b1 && exp_q.size() > 0)
      check(o_tgt_wdata, exp_q.pop_front());
  end
  // Hang guard, well above the expected run
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    {i_req_valid, i_req_locked, i_req_multi, i_req_prefetch, i_req_more, i_lock_active} = '0;
    {i_boundary, i_no_rd_data, i_pw_valid, frc, clr, dis, i_resetn, i_no_wr_room, i_mto_expire} = '0;
    {i_req_kind, i_req_addr, i_req_cmd, i_pw_data, m_term, m_words} = '0;
    i_req_dwords = 16'h0001;
    i_serr_en = 1'b1;
    i_pw_space_dw = 8'hff;
    m_lat = 4'h1;
    rnd = 32'h00000028;
    repeat (8) @(posedge i_mclk);
    check({o_serr_n, o_ans_valid, o_tgt_start, o_sig_serr}, 4'h8);
    @(negedge i_mclk);
    i_resetn = 1'b1;
    // Delayed transfers: every target code except retry, both kinds, random side conditions
    for (int i = 0; i < 16; i++)
    begin
      rnd = xs(rnd);
      k = i[2] ? `BTRM_K_DR : `BTRM_K_DW;
      t = TC[i[1:0]];
      f = i[2] ? rnd[4:0] : {rnd[4], 4'h0};
      {i_req_multi, i_req_prefetch, i_req_more, i_boundary, i_no_rd_data} = f;
      base = xs(rnd) & 32'hffff_fffc;
      c = rnd[11:8];
      m_term = t;
      m_lat = 4'h4 + {2'h0, rnd[13:12]};
      s0 = starts;
      v0 = dones;
      req(k, base, c, `BTRM_A_RETRY);
      req(k, base, c, `BTRM_A_RETRY);
      wait_for(starts, s0 + 1);
      check({st_post, st_cmd, st_addr}, {1'b0, c, base});
      wait_for(dones, v0 + 1);
      // Writes only wait on the queue head, reads on all three
      frc[2:0] = i[2] ? rnd[16:14] : {rnd[16], 2'h0};
      if (frc != 5'h0)
        req(k, base, c, `BTRM_A_RETRY);
      frc = 5'h0;
      req(k, base, c, exp_ans(k, t, f));
      if (t == `BTRM_T_TABORT)
      begin
        check({o_rx_tabort, o_sig_tabort}, 2'h3);
        clr = 3'h7;
        @(negedge i_mclk);
        clr = 3'h0;
        @(negedge i_mclk);
        check({o_rx_tabort, o_sig_tabort, o_sig_serr}, 3'h0);
      end
    end
    // Fill the buffer until it refuses, then deliver over a disconnect and a retry
    for (int w = 0; w < 4; w++)
    begin
      @(negedge i_mclk);
      rnd = xs(rnd);
      i_pw_valid = 1'b1;
      i_pw_data = rnd;
      exp_q.push_back(rnd);
    end
    @(negedge i_mclk);
    i_pw_valid = 1'b0;
    check(o_pw_ready, 1'b0);
    base = rnd & 32'hffff_fff0;
    i_req_dwords = 16'h0004;
    i_pw_space_dw = {5'h0, rnd[6:4]};
    req(`BTRM_K_PW, base, `BTRM_CMD_MWI, `BTRM_A_RETRY);
    i_pw_space_dw = `BTRM_PW_MIN_DW;
    i_lock_active = 1'b1;
    req(`BTRM_K_PW, base, `BTRM_CMD_MWI, `BTRM_A_RETRY);
    {i_lock_active, i_boundary} = 2'h0;
    m_term = `BTRM_T_DISC;
    m_words = 4'h1;
    m_lat = 4'h2;
    s0 = starts;
    v0 = dones;
    req(`BTRM_K_PW, base, `BTRM_CMD_MWI, `BTRM_A_ACCEPT);
    attempt(base, `BTRM_CMD_MWI, `BTRM_T_RETRY, 4'h0);
    attempt(base + 32'h4, `BTRM_CMD_MW, `BTRM_T_NORMAL, 4'h3);
    attempt(base + 32'h4, `BTRM_CMD_MW, `BTRM_T_NORMAL, 4'h0);
    check({o_pw_ready, 31'(exp_q.size())}, 32'h80000000);
    // Posted write that never gets through, then one that is target-aborted
    for (int j = 0; j < 2; j++)
    begin
      @(negedge i_mclk);
      i_pw_valid = 1'b1;
      @(negedge i_mclk);
      i_pw_valid = 1'b0;
      i_req_dwords = 16'h0001;
      m_term = j ? `BTRM_T_TABORT : `BTRM_T_RETRY;
      i_no_wr_room = j[0];
      s0 = starts;
      v0 = serrs;
      req(`BTRM_K_PW, base, `BTRM_CMD_MW, j ? `BTRM_A_DISC : `BTRM_A_ACCEPT);
      wait_for(starts, s0 + (j ? 1 : LIMN));
      repeat (12) @(negedge i_mclk);
      check(starts - s0, j ? 1 : LIMN);
      check(serrs - v0, 1);
      check({o_sig_serr, o_rx_tabort}, {1'b1, j[0]});
    end
    // Delayed transfers always retried, with the error report on, masked and off
    m_term = `BTRM_T_RETRY;
    for (int j = 0; j < 4; j++)
    begin
      k = j[0] ? `BTRM_K_DR : `BTRM_K_DW;
      i_serr_en = (j != 3);
      dis = (j == 2) ? 4'h8 : 4'h0;
      base = base + 32'h40;
      s0 = starts;
      v0 = serrs;
      req(k, base, 4'h6, `BTRM_A_RETRY);
      wait_for(starts, s0 + LIMN);
      repeat (12) @(negedge i_mclk);
      check(starts - s0, LIMN);
      check(serrs - v0, j < 2);
      // Last round: a master timeout drops the aborted slot, so the repeat is new
      i_mto_expire = (j == 3);
      @(negedge i_mclk);
      i_mto_expire = 1'b0;
      req(k, base, 4'h6, (j == 3) ? `BTRM_A_RETRY : `BTRM_A_TABORT);
      check(o_sig_tabort, 1'b1);
    end
    print_verdict();
  end
endmodule
